// >>> verilog/lro_rx_output_formatter.sv
/*
 * lro_fifo and lro_rx_output_formatter: receive output stage of one line channel.
 * Recovered symbols arrive from the decoder with valid/ready, pass a small FIFO and
 * are launched to the terminal with a rebuilt recovered clock. Inputs are taken as
 * synchronous to clk; the host port writes the configuration word directly.
 */
//
// Summary of operation
// - deliver data and clock, dual or single rail
// - normal clock: data changes on rising edge
// - recovered clock: one-cycle half period in every mode
// - dual rail: positive pulse drives positive output
// - dual rail: negative pulse drives negative output
// - hardware pin high: launch on falling edge
// - host mode: config bit inverts channel clock
// - host mode: config bit selects single rail
// - single rail: binary stream on positive output
// - hardware pin selects rail format globally
// - single rail: negative output held at zero
// - hardware pin shuts receive section off
// - host mode: config bit shuts receiver off
// - config word holds four control bits and a reserved bit
// - mute on loss of signal zeroes both data outputs
`timescale 1ns/1ns

module lro_fifo
    import lro_pkg::*;
#(
    parameter int WIDTH = SYM_W,
    parameter int DEPTH = FIFO_DEPTH
)(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    logic             notFull_q;
    wire              doWr;
    wire              doRd;
    wire  [AW:0]      countD;

    // pointer moves and occupancy
    assign doWr   = inValid && notFull_q && !flush;
    assign doRd   = outReady && (count_q != '0) && !flush;
    assign countD = flush ? '0 : count_q + (AW+1)'(doWr) - (AW+1)'(doRd);
    assign inReady  = notFull_q;
    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];

    // storage has no reset; only pointers define contents
    always_ff @(posedge clk)
    begin
        if (doWr)
            mem[wrPtr_q] <= inData;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || flush)
        begin
            wrPtr_q   <= '0;
            rdPtr_q   <= '0;
            count_q   <= '0;
            notFull_q <= 1'b1;
        end
        else
        begin
            wrPtr_q   <= doWr ? AW'(wrPtr_q + 1'b1) : wrPtr_q;
            rdPtr_q   <= doRd ? AW'(rdPtr_q + 1'b1) : rdPtr_q;
            count_q   <= countD;
            notFull_q <= (countD != (AW+1)'(DEPTH));
        end
    end
endmodule

module lro_rx_output_formatter
    import lro_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
)(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // mode and global hardware pins
    input  wire logic             hostMode,
    input  wire logic [1:0]       rateSel,
    input  wire logic             globalClockInvertPin,
    input  wire logic             railFormatPin,
    input  wire logic             receiverOffPin,
    input  wire logic             muteEnablePin,
    input  wire logic             signalLoss,
    // configuration register port
    input  wire logic             cfgWrEn,
    input  wire logic [CFG_W-1:0] cfgWrData,
    output logic      [CFG_W-1:0] cfgRdData,
    // recovered symbols from the decoder
    input  wire logic             symValid,
    output logic                  symReady,
    input  wire logic [SYM_W-1:0] symData,
    // terminal side
    output logic                  positiveDataOut,
    output logic                  negativeDataOut,
    output logic                  recoveredClockOut
);
    logic [CFG_W-1:0]      receiveOutputConfig_q;
    logic [CFG_W-1:0]      cfgRd_q;
    lro_rx_state_e         state_q;
    logic [HALF_CNT_W-1:0] halfCnt_q;
    logic                  phase_q;
    logic                  pos_q;
    logic                  neg_q;
    logic                  clkOut_q;
    wire                   clockInvert;
    wire                   singleRail;
    wire                   receiverShutdown;
    wire                   muteOnSignalLoss;
    wire                   muted;
    wire                   running;
    wire                   halfTick;
    wire                   launch;
    wire                   phaseD;
    wire [HALF_CNT_W-1:0]  halfLoad;
    wire                   fifoValid;
    wire [SYM_W-1:0]       fifoData;
    wire [SYM_W-1:0]       symNow;
    wire                   posD;
    wire                   negD;

    // host mode takes per-channel bits, hardware mode the global pins
    assign clockInvert      = hostMode ? receiveOutputConfig_q[CFG_CLKINV_BIT]
                                       : globalClockInvertPin;
    assign singleRail       = hostMode ? receiveOutputConfig_q[CFG_SINGLE_BIT]
                                       : railFormatPin;
    assign receiverShutdown = hostMode ? receiveOutputConfig_q[CFG_RXOFF_BIT]
                                       : receiverOffPin;
    assign muteOnSignalLoss = hostMode ? receiveOutputConfig_q[CFG_MUTE_BIT]
                                       : muteEnablePin;
    assign muted            = muteOnSignalLoss && signalLoss;
    assign running          = (state_q == RX_RUN);

    // half period reload per line mode; unknown codes fall back to the slowest rate
    assign halfLoad = (rateSel == RATE_SEL_DS3)  ? HALF_CNT_W'(HALF_DS3_CYC - 1)
                    : (rateSel == RATE_SEL_STS1) ? HALF_CNT_W'(HALF_STS1_CYC - 1)
                    : HALF_CNT_W'(HALF_E3_CYC - 1);
    assign halfTick = running && (halfCnt_q == '0);
    assign phaseD   = halfTick ? !phase_q : phase_q;
    // data is launched on the internal rising phase; inversion only flips the pin
    assign launch   = halfTick && !phase_q;

    // symbol launched now, zero when the decoder fell behind
    assign symNow = fifoValid ? fifoData : '0;
    assign posD   = singleRail ? symNow[SYM_BIN_BIT] : symNow[SYM_POS_BIT];
    assign negD   = symNow[SYM_NEG_BIT];

    assign cfgRdData         = cfgRd_q;
    assign positiveDataOut   = pos_q;
    assign negativeDataOut   = neg_q;
    assign recoveredClockOut = clkOut_q;

    // shutdown discards buffered symbols so a restart never replays stale data
    lro_fifo #(
        .WIDTH (SYM_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .flush    (!running),
        .inValid  (symValid),
        .inReady  (symReady),
        .inData   (symData),
        .outValid (fifoValid),
        .outReady (launch),
        .outData  (fifoData)
    );

    // configuration word; the reserved bit always reads zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            receiveOutputConfig_q <= CFG_RESET;
            cfgRd_q               <= CFG_RESET;
        end
        else
        begin
            if (cfgWrEn)
                receiveOutputConfig_q <= cfgWrData & CFG_WR_MASK;
            cfgRd_q <= receiveOutputConfig_q;
        end
    end

    // receive section on/off
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state_q <= RX_OFF;
        else
            state_q <= receiverShutdown ? RX_OFF : RX_RUN;
    end

    // divider producing half-period ticks of the recovered clock
    always_ff @(posedge clk)
    begin
        if (!rst_n || !running)
        begin
            halfCnt_q <= '0;
            phase_q   <= 1'b0;
        end
        else
        begin
            halfCnt_q <= (halfCnt_q == '0) ? halfLoad : HALF_CNT_W'(halfCnt_q - 1'b1);
            phase_q   <= phaseD;
        end
    end

    // terminal pins; forced zeros act at once, not at the next launch
    always_ff @(posedge clk)
    begin
        if (!rst_n || !running)
        begin
            pos_q    <= 1'b0;
            neg_q    <= 1'b0;
            clkOut_q <= 1'b0;
        end
        else
        begin
            clkOut_q <= phaseD ^ clockInvert;
            if (muted)
                pos_q <= 1'b0;
            else if (launch)
                pos_q <= posD;
            if (muted || singleRail)
                neg_q <= 1'b0;
            else if (launch)
                neg_q <= negD;
        end
    end

    // checks
    sequence sLaunchDual;
        launch && !singleRail && !muted && fifoValid;
    endsequence

    sequence sLaunchSingle;
        launch && singleRail && !muted && fifoValid;
    endsequence

    a_single_neg_zero: assert property (@(posedge clk) disable iff (!rst_n)
        running && singleRail |=> !negativeDataOut)
        else $error("negative output not zero in single rail");

    a_mute_zero: assert property (@(posedge clk) disable iff (!rst_n)
        running && muted |=> !positiveDataOut && !negativeDataOut)
        else $error("outputs not muted during signal loss");

    // shutdown reaches the pins two cycles later: state flop first, then the pin flops
    a_off_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        receiverShutdown |=> ##1 (!recoveredClockOut && !positiveDataOut && !negativeDataOut))
        else $error("receive section active while shut off");

    // a restart or a change of the invert setting moves the pin without a launch edge
    a_launch_rise: assert property (@(posedge clk) disable iff (!rst_n)
        launch && !clockInvert && $past(running) && $stable(clockInvert)
        |=> $rose(recoveredClockOut))
        else $error("data launch not on rising clock edge");

    a_launch_fall: assert property (@(posedge clk) disable iff (!rst_n)
        launch && clockInvert && $past(running) && $stable(clockInvert)
        |=> $fell(recoveredClockOut))
        else $error("inverted clock not falling at data launch");

    a_dual_pos: assert property (@(posedge clk) disable iff (!rst_n)
        sLaunchDual |=> positiveDataOut == $past(fifoData[SYM_POS_BIT]))
        else $error("positive output does not follow positive pulse");

    a_dual_neg: assert property (@(posedge clk) disable iff (!rst_n)
        sLaunchDual |=> negativeDataOut == $past(fifoData[SYM_NEG_BIT]))
        else $error("negative output does not follow negative pulse");

    a_single_bin: assert property (@(posedge clk) disable iff (!rst_n)
        sLaunchSingle |=> positiveDataOut == $past(fifoData[SYM_BIN_BIT]))
        else $error("binary stream not on positive output");

    a_cfg_write: assert property (@(posedge clk) disable iff (!rst_n)
        cfgWrEn ##1 !cfgWrEn |=> cfgRdData == ($past(cfgWrData, 2) & CFG_WR_MASK))
        else $error("configuration readback mismatch");

    a_clk_toggle: assert property (@(posedge clk) disable iff (!rst_n)
        running && $past(running) && !$changed(clockInvert) && (halfCnt_q == '0)
        |=> $changed(recoveredClockOut))
        else $error("recovered clock did not toggle on half period");
endmodule

// >>> verilog/lro_pkg.sv
/*
 * lro_pkg: shared constants for the receive output formatter of one line channel.
 * Assumes a single 100 MHz system clock; the recovered line clock is rebuilt
 * from it by a divider that produces half-period enable pulses.
 */
package lro_pkg;

    // system clock
    localparam int CLK_FREQ_KHZ = 100000;

    // nominal recovered clock rates per line mode
    localparam int RATE_E3_KHZ   = 34368;
    localparam int RATE_DS3_KHZ  = 44736;
    localparam int RATE_STS1_KHZ = 51840;

    // half period of the recovered clock in system cycles: rounded down, at least one
    localparam int HALF_E3_RAW   = CLK_FREQ_KHZ / (2 * RATE_E3_KHZ);
    localparam int HALF_DS3_RAW  = CLK_FREQ_KHZ / (2 * RATE_DS3_KHZ);
    localparam int HALF_STS1_RAW = CLK_FREQ_KHZ / (2 * RATE_STS1_KHZ);
    localparam int HALF_E3_CYC   = (HALF_E3_RAW > 0) ? HALF_E3_RAW : 1;
    localparam int HALF_DS3_CYC  = (HALF_DS3_RAW > 0) ? HALF_DS3_RAW : 1;
    localparam int HALF_STS1_CYC = (HALF_STS1_RAW > 0) ? HALF_STS1_RAW : 1;
    localparam int HALF_CNT_W    = 8;

    // line mode select codes
    localparam logic [1:0] RATE_SEL_E3   = 2'h0;
    localparam logic [1:0] RATE_SEL_DS3  = 2'h1;
    localparam logic [1:0] RATE_SEL_STS1 = 2'h2;

    // receive output configuration register layout
    localparam int         CFG_W         = 5;
    localparam int         CFG_RSVD_BIT  = 0;
    localparam int         CFG_CLKINV_BIT = 1;
    localparam int         CFG_RXOFF_BIT = 2;
    localparam int         CFG_MUTE_BIT  = 3;
    localparam int         CFG_SINGLE_BIT = 4;
    localparam logic [4:0] CFG_RESET     = 5'h00;
    localparam logic [4:0] CFG_WR_MASK   = 5'h1e;

    // recovered symbol word: bit 0 positive pulse, bit 1 negative pulse, bit 2 binary
    localparam int SYM_W       = 3;
    localparam int SYM_POS_BIT = 0;
    localparam int SYM_NEG_BIT = 1;
    localparam int SYM_BIN_BIT = 2;
    localparam int FIFO_DEPTH  = 32;

    typedef enum logic {RX_OFF, RX_RUN} lro_rx_state_e;

endpackage

// >>> test/lro_term_model.sv
/*
 * lro_term_model: receiving terminal that samples the formatter pins.
 * Assumes pins synchronous to clk; invertSel picks the sampling edge.
 */
`timescale 1ns/1ns
module lro_term_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // setup and formatter pins
    input  wire logic invertSel,
    input  wire logic posIn,
    input  wire logic negIn,
    input  wire logic rclkIn,
    // captured bits and timing faults
    output logic      sampleValid,
    output logic      samplePos,
    output logic      sampleNeg,
    output logic      edgeFault
);
    logic      prevClk_q;
    logic      prevPos_q;
    logic      prevNeg_q;
    wire logic sampleEdge;
    wire logic dataMoved;

    // sample opposite the launch edge; data moving there breaks setup
    assign sampleEdge = (prevClk_q != rclkIn) && (rclkIn == invertSel);
    assign dataMoved  = (posIn != prevPos_q) || (negIn != prevNeg_q);

    // no backpressure: a framer never stalls the line
    always_ff @(posedge clk)
    begin
        samplePos <= posIn;
        sampleNeg <= negIn;
        if (!rst_n)
        begin
            {prevClk_q, prevPos_q, prevNeg_q, sampleValid, edgeFault} <= 5'h00;
        end
        else
        begin
            {prevClk_q, prevPos_q, prevNeg_q} <= {rclkIn, posIn, negIn};
            sampleValid <= sampleEdge;
            edgeFault <= sampleEdge && dataMoved;
        end
    end
endmodule

// >>> test/tb.sv
/*
 * tb: self-checking bench for the receive output formatter.
 * Assumes lro_pkg and lro_term_model are compiled first; clock 100 MHz.
 */
`timescale 1ns/1ns
module tb import lro_pkg::*; ();
    // design and model connections
    logic             clk, rst_n, hostMode, invPin, railPin, offPin, mutePin, signalLoss;
    logic             cfgWrEn, symValid, symReady, posOut, negOut, rclk, termInv;
    logic             sampleValid, samplePos, sampleNeg, edgeFault;
    logic [1:0]       rateSel;
    logic [CFG_W-1:0] cfgWrData, cfgRdData;
    logic [SYM_W-1:0] symData;
    logic [1:0]       expQ[$], capQ[$];
    logic [2:0]       modeTab[6] = '{3'h4, 3'h7, 3'h2, 3'h1, 3'h5, 3'h3};
    int               errCount, nCompared, violCnt, stallCnt, seed;

    lro_rx_output_formatter dut (
        .clk(clk), .rst_n(rst_n), .hostMode(hostMode), .rateSel(rateSel),
        .globalClockInvertPin(invPin), .railFormatPin(railPin), .receiverOffPin(offPin),
        .muteEnablePin(mutePin), .signalLoss(signalLoss), .cfgWrEn(cfgWrEn),
        .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .symValid(symValid),
        .symReady(symReady), .symData(symData), .positiveDataOut(posOut),
        .negativeDataOut(negOut), .recoveredClockOut(rclk)
    );
    lro_term_model term (
        .clk(clk), .rst_n(rst_n), .invertSel(termInv), .posIn(posOut), .negIn(negOut),
        .rclkIn(rclk), .sampleValid(sampleValid), .samplePos(samplePos),
        .sampleNeg(sampleNeg), .edgeFault(edgeFault)
    );

    // system clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // collect what the terminal saw and count setup faults
    always @(posedge clk)
    begin
        if (sampleValid === 1'b1)
            capQ.push_back({sampleNeg, samplePos});
        if (edgeFault === 1'b1)
            violCnt++;
        if (symValid === 1'b1 && symReady === 1'b0)
            stallCnt++;
    end

    // hang guard: the run needs about 3000 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        errCount++;
        testDone();
    end

    task automatic testDone;
        $display("compared %0d, mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic checkPins(input logic [1:0] got, input logic [1:0] exp, input string what);
        nCompared++;
        if (got !== exp)
        begin
            errCount++;
            $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic checkCfg(input logic [4:0] got, input logic [4:0] exp, input string what);
        nCompared++;
        if (got !== exp)
        begin
            errCount++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // pins expected for one symbol: {negative, positive}
    function automatic logic [1:0] expPins(input logic [2:0] d, input logic single);
        return single ? {1'b0, d[SYM_BIN_BIT]} : {d[SYM_NEG_BIT], d[SYM_POS_BIT]};
    endfunction

    // legal line symbol: never a positive and a negative pulse together
    function automatic logic [2:0] randSym;
        logic [31:0] r;
        r = $random(seed);
        return {r[4], r[1:0] == 2'h2, r[1:0] == 2'h1};
    endfunction

    task automatic cfgWrite(input logic [CFG_W-1:0] v);
        @(posedge clk);
        cfgWrEn <= 1'b1;
        cfgWrData <= v;
        @(posedge clk);
        cfgWrEn <= 1'b0;
    endtask

    // the unused source (pins or register) gets the opposite setting on purpose
    task automatic applyMode(input logic host, single, inv, mute, off);
        logic [3:0] set;
        set = {single, mute, off, inv};
        @(posedge clk);
        hostMode <= host;
        rateSel <= 2'($random(seed));
        {railPin, mutePin, offPin, invPin} <= host ? ~set : set;
        termInv <= inv;
        cfgWrite(host ? {set, 1'b1} : {~set, 1'b1});
        repeat (4) @(posedge clk);
    endtask

    // ready is a flop: read it mid-cycle, the word is taken at the next rising edge
    task automatic sendSym(input logic [2:0] d, input logic single);
        int n;
        n = 0;
        symValid <= 1'b1;
        symData <= d;
        @(negedge clk);
        while (symReady !== 1'b1 && n < 200)
        begin
            n++;
            @(negedge clk);
        end
        @(posedge clk);
        if (n >= 200)
            errCount++;
        expQ.push_back(expPins(d, single));
    endtask

    // marker 3'h5 shows a one on the positive pin in both formats
    task automatic burst(input int n, input logic single);
        @(posedge clk);
        sendSym(3'h5, single);
        repeat (n - 1) sendSym(randSym(), single);
        symValid <= 1'b0;
    endtask

    task automatic runPhase(input logic host, single, inv, mute);
        applyMode(host, single, inv, mute, 1'b0);
        repeat (6) @(posedge clk);
        capQ.delete();
        expQ.delete();
        violCnt = 0;
        stallCnt = 0;
        // one word per cycle outruns the drain, so the buffer must fill and stall
        burst(80, single);
        repeat (120) @(posedge clk);
        checkPins({1'b0, violCnt != 0}, 2'h0, "edge");
        checkPins({1'b0, stallCnt == 0}, 2'h0, "ready");
        while (capQ.size() > 0 && capQ[0][0] !== 1'b1)
            checkPins(capQ.pop_front(), 2'h0, "idle");
        foreach (expQ[i])
            checkPins(capQ.size() > 0 ? capQ.pop_front() : 2'bxx, expQ[i], "data");
    endtask

    task automatic muteCheck(input logic host);
        applyMode(host, 1'b0, 1'b0, 1'b1, 1'b0);
        burst(24, 1'b0);
        signalLoss <= 1'b1;
        repeat (2) @(negedge clk);
        repeat (16)
        begin
            @(negedge clk);
            checkPins({negOut, posOut}, 2'h0, "muted");
        end
        @(posedge clk);
        signalLoss <= 1'b0;
        runPhase(host, 1'b0, 1'b0, 1'b1);
    endtask

    // shut off with symbols still buffered; nothing stale may show after turn-on
    task automatic offCheck(input logic host);
        applyMode(host, 1'b0, 1'b0, 1'b0, 1'b0);
        burst(40, 1'b0);
        applyMode(host, 1'b0, 1'b1, 1'b0, 1'b1);
        repeat (12)
        begin
            @(negedge clk);
            checkPins({negOut, posOut}, 2'h0, "off data");
            checkPins({1'b0, rclk}, 2'h0, "off clock");
        end
        runPhase(host, 1'b0, 1'b1, 1'b0);
    endtask

    // main sequence
    initial
    begin
        logic [CFG_W-1:0] wr;
        seed = 32'hb5c47341;
        errCount = 0;
        nCompared = 0;
        {rst_n, hostMode, invPin, railPin, offPin, mutePin, signalLoss, cfgWrEn} = '0;
        {symValid, termInv, rateSel, cfgWrData, symData} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        checkCfg(cfgRdData, 5'h00, "reset");
        cfgWrite(5'h1f);
        repeat (2) @(negedge clk);
        checkCfg(cfgRdData, 5'h1e, "reserved");
        repeat (4)
        begin
            wr = 5'($random(seed));
            cfgWrite(wr);
            repeat (2) @(negedge clk);
            checkCfg(cfgRdData, wr & 5'h1e, "config");
        end
        foreach (modeTab[i])
            runPhase(modeTab[i][2], modeTab[i][1], modeTab[i][0], 1'b0);
        muteCheck(1'b1);
        muteCheck(1'b0);
        offCheck(1'b1);
        offCheck(1'b0);
        testDone();
    end
endmodule
